// ### logic/ttcs_top.v
/*
 Transmit timing clock select: picks the jitter attenuator FIFO output
 clock and PLL reference, routes loopback and elastic-store bypass paths,
 and holds the timing registers behind a classic Wishbone slave.
 Assumes the line-side clocks and data arrive asynchronously on pins and
 are far slower than clk_i, so sampled levels are an adequate model.
*/
`timescale 1ns/10ps
`include "ttcs_regs.vh"
module ttcs_top (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`TTCS_ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire backplane_tx_clock_i,
  input wire tx_ref_clock_in_i,
  input wire rx_recovered_clock_i,
  input wire atten_clock_i,
  input wire store_clock_i,
  input wire tx_data_i,
  input wire rx_data_i,
  input wire store_data_i,
  output reg tx_line_clock_out_o,
  output reg fifo_in_clock_o,
  output reg fifo_in_data_o,
  output reg pll_ref_clock_o,
  output reg backplane_ref_clock_o,
  output reg atten_bypass_o,
  output reg line_loopback_en_o,
  output reg tx_elastic_bypass_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling

  wire [7:0] pins_sync;

  ttcs_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({store_data_i, rx_data_i, tx_data_i, store_clock_i,
              atten_clock_i, rx_recovered_clock_i, tx_ref_clock_in_i,
              backplane_tx_clock_i}),
    .sync_o(pins_sync)
  );

  wire bp_clk = pins_sync[0];
  wire ref_clk = pins_sync[1];
  wire rec_clk = pins_sync[2];
  wire att_clk = pins_sync[3];
  wire st_clk = pins_sync[4];
  wire tx_dat = pins_sync[5];
  wire rx_dat = pins_sync[6];
  wire st_dat = pins_sync[7];

  ////////////////////////////////////////////////////////////////////////
  // Registers

  reg [1:0] fifo_out_clk_sel_reg;
  reg [1:0] pll_ref_sel_reg;
  reg tx_elastic_bypass_reg;
  reg line_loopback_en_reg;
  reg backplane_clock_dir_reg;
  reg tx_unipolar_sel_reg;

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire hit_timing = (wb_adr_i == `TTCS_OFS_TIMING);
  wire hit_ctrl = (wb_adr_i == `TTCS_OFS_CTRL);
  wire hit_status = (wb_adr_i == `TTCS_OFS_STATUS);

  always @(posedge clk_i) begin
    if (rst_i) begin
      fifo_out_clk_sel_reg <= `TTCS_SEL_RST; // R7
      pll_ref_sel_reg <= `TTCS_SEL_RST; // R7
      tx_elastic_bypass_reg <= `TTCS_BYP_RST;
      line_loopback_en_reg <= 1'b0;
      backplane_clock_dir_reg <= 1'b1;
      tx_unipolar_sel_reg <= 1'b0;
    end else if (bus_wr && hit_timing) begin
      fifo_out_clk_sel_reg <= wb_dat_i[`TTCS_TIM_OUTSEL_HI:`TTCS_TIM_OUTSEL_LO];
      pll_ref_sel_reg <= wb_dat_i[`TTCS_TIM_REF_HI:`TTCS_TIM_REF_LO];
      tx_elastic_bypass_reg <= wb_dat_i[`TTCS_TIM_BYP];
    end else if (bus_wr && hit_ctrl) begin
      line_loopback_en_reg <= wb_dat_i[`TTCS_CTRL_LOOP];
      backplane_clock_dir_reg <= wb_dat_i[`TTCS_CTRL_DIR];
      tx_unipolar_sel_reg <= wb_dat_i[`TTCS_CTRL_UNI];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock and data selection

  reg fifo_in_clk;
  reg fifo_in_dat;
  reg pll_ref;
  reg fifo_out_clk;
  reg atten_off;

  // Software-side mistakes are reported, not corrected, so the chosen
  // timing is never silently altered behind the driver's back.
  wire err_ref_sel01 = (fifo_out_clk_sel_reg == `TTCS_OUT_REF) &&
                       (pll_ref_sel_reg != `TTCS_REF_EXTERNAL); // R2
  wire err_ref_sel1x = fifo_out_clk_sel_reg[1] &&
                       (pll_ref_sel_reg != `TTCS_REF_FIFO_IN); // R3
  wire err_self_ref = ~backplane_clock_dir_reg &&
                      ~pll_ref_sel_reg[1]; // R6
  wire err_bipolar_ref = ~tx_unipolar_sel_reg &&
                         fifo_out_clk_sel_reg[1] &&
                         (pll_ref_sel_reg != `TTCS_REF_FIFO_IN); // R8

  always @* begin
    fifo_in_clk = bp_clk;
    fifo_in_dat = tx_dat;
    if (line_loopback_en_reg) begin
      fifo_in_clk = rec_clk; // R5
      fifo_in_dat = rx_dat; // R15 R17
    end else if (!tx_elastic_bypass_reg) begin
      fifo_in_clk = st_clk; // R12
      fifo_in_dat = st_dat; // R12
    end else begin
      fifo_in_clk = bp_clk; // R16
      fifo_in_dat = tx_dat; // R16
    end
    case (pll_ref_sel_reg)
      `TTCS_REF_FIFO_IN: pll_ref = fifo_in_clk; // R4 R5 R9
      `TTCS_REF_BACKPLANE: pll_ref = bp_clk; // R4
      `TTCS_REF_RECOVERED: pll_ref = rec_clk; // R4 R10
      default: pll_ref = ref_clk; // R4 R11
    endcase
    atten_off = 1'b0;
    if (fifo_out_clk_sel_reg[1]) begin
      fifo_out_clk = fifo_in_clk; // R3 R13
      atten_off = 1'b1; // R13
    end else if (fifo_out_clk_sel_reg == `TTCS_OUT_REF) begin
      fifo_out_clk = ref_clk; // R2 R14
      atten_off = 1'b1; // R14
    end else begin
      fifo_out_clk = att_clk; // R1 R9 R10
    end
  end

  // Outputs are registered so that selection glitches never reach the pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_line_clock_out_o <= 1'b0;
      fifo_in_clock_o <= 1'b0;
      fifo_in_data_o <= 1'b0;
      pll_ref_clock_o <= 1'b0;
      backplane_ref_clock_o <= 1'b0;
      atten_bypass_o <= 1'b0;
      line_loopback_en_o <= 1'b0;
      tx_elastic_bypass_o <= `TTCS_BYP_RST;
    end else begin
      tx_line_clock_out_o <= fifo_out_clk; // R1 R13 R14
      fifo_in_clock_o <= fifo_in_clk;
      fifo_in_data_o <= fifo_in_dat; // R15
      pll_ref_clock_o <= pll_ref;
      backplane_ref_clock_o <= ~backplane_clock_dir_reg & pll_ref; // R11
      atten_bypass_o <= atten_off;
      line_loopback_en_o <= line_loopback_en_reg; // R17
      tx_elastic_bypass_o <= tx_elastic_bypass_reg; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus read and acknowledge

  reg [31:0] rd_data;

  always @* begin
    rd_data = 32'h0000_0000;
    if (hit_timing) begin
      rd_data[`TTCS_TIM_OUTSEL_HI:`TTCS_TIM_OUTSEL_LO] = fifo_out_clk_sel_reg;
      rd_data[`TTCS_TIM_REF_HI:`TTCS_TIM_REF_LO] = pll_ref_sel_reg;
      rd_data[`TTCS_TIM_BYP] = tx_elastic_bypass_reg;
    end else if (hit_ctrl) begin
      rd_data[`TTCS_CTRL_LOOP] = line_loopback_en_reg;
      rd_data[`TTCS_CTRL_DIR] = backplane_clock_dir_reg;
      rd_data[`TTCS_CTRL_UNI] = tx_unipolar_sel_reg;
    end else if (hit_status) begin
      rd_data[0] = ~atten_off;
      rd_data[1] = err_ref_sel01;
      rd_data[2] = err_ref_sel1x;
      rd_data[3] = err_self_ref;
      rd_data[4] = err_bipolar_ref;
      rd_data[5] = tx_line_clock_out_o;
      rd_data[6] = pll_ref_clock_o;
    end
  end

  // Unmapped offsets read zero and drop writes, but are still acknowledged
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule // ttcs_top

// ### logic/ttcs_regs.vh
/*
 Constants for the transmit timing clock select block: register offsets,
 field positions and reset values. Assumes a 32-bit classic Wishbone slave
 with byte addresses.
*/
// Summary of operation
// [R1] Select 00: FIFO output on attenuated clock
// [R2] Select 01: FIFO output on reference; ref 11
// [R3] Select 1x: FIFO input clock, ref 00
// [R4] Reference select picks one of four clocks
// [R5] Reference 00 follows whatever feeds FIFO input
// [R6] Backplane output: reference recovered or external only
// [R7] Reset clears both select fields
// [R8] Bipolar line: reference must suit 24x clock
// [R9] Default mode references line clock to backplane
// [R10] Reference 10 loop-times to recovered clock
// [R11] Reference 11 ties line and backplane out
// [R12] Elastic store accepts plesiochronous backplane clock
// [R13] Select 1x: no attenuation, line equals backplane
// [R14] Select 01, ref 11: line equals reference
// [R15] Loopback sends received data, attenuated
// [R16] Bypass routes store input straight to output
// [R17] Loopback feeds recovered data to attenuator
`ifndef TTCS_REGS_VH
`define TTCS_REGS_VH

`define TTCS_CLK_HZ 50000000
`define TTCS_T1_RATE_KHZ 1544
`define TTCS_E1_RATE_KHZ 2048

`define TTCS_ADDR_W 4
`define TTCS_OFS_TIMING 4'h0
`define TTCS_OFS_CTRL 4'h4
`define TTCS_OFS_STATUS 4'h8

`define TTCS_TIM_OUTSEL_HI 5
`define TTCS_TIM_OUTSEL_LO 4
`define TTCS_TIM_REF_HI 3
`define TTCS_TIM_REF_LO 2
`define TTCS_TIM_BYP 0
`define TTCS_SEL_RST 2'h0
`define TTCS_BYP_RST 1'b1

`define TTCS_CTRL_LOOP 0
`define TTCS_CTRL_DIR 1
`define TTCS_CTRL_UNI 2

`define TTCS_OUT_ATTEN 2'h0
`define TTCS_OUT_REF 2'h1
`define TTCS_REF_FIFO_IN 2'h0
`define TTCS_REF_BACKPLANE 2'h1
`define TTCS_REF_RECOVERED 2'h2
`define TTCS_REF_EXTERNAL 2'h3

`endif

// ### logic/ttcs_sync.v
/*
 Two flip-flop synchroniser for a bundle of asynchronous levels.
 Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/10ps
module ttcs_sync #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_reg;

  // The first stage feeds the second stage only
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule // ttcs_sync

// ### tb/ttcs_far_model.sv
/* Far-side model: line and backplane clocks plus data levels.
   Assumes the bench clock paces it. */
`timescale 1ns/10ps
module ttcs_far_model (
  input wire clk_i,
  input wire run_i,
  input wire [7:0] pat_i,
  output reg [7:0] pins_o
);
  reg [7:0] cnt = 8'h00;
  initial pins_o = 8'h00;
  // Clocks toggle only while run_i is high; a fixed pattern makes routing visible
  always @(posedge clk_i) begin
    cnt <= cnt + 8'h01;
    pins_o <= run_i ? {cnt[7:6], ~cnt[5], cnt[4:0]} : pat_i;
  end
endmodule // ttcs_far_model

// ### tb/ttcs_chk.sv
/* Port checker for ttcs_top.
   Assumes it is bound onto ttcs_top. */
`timescale 1ns/10ps
module ttcs_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire rx_data_i,
  input wire rx_recovered_clock_i,
  input wire atten_clock_i,
  input wire fifo_in_data_o,
  input wire fifo_in_clock_o,
  input wire tx_line_clock_out_o,
  input wire atten_bypass_o,
  input wire line_loopback_en_o,
  input wire tx_elastic_bypass_o,
  input wire pll_ref_clock_o,
  input wire backplane_ref_clock_o
);
  // Pin paths need three clean edges after reset before they match
  reg [3:0] rh;
  wire ok = (rh == 4'h0);
  always @(posedge clk_i) rh <= {rh[2:0], rst_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_on_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  chk_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  chk_reset_state:
    assert property ($fell(rst_i) |-> tx_elastic_bypass_o && !atten_bypass_o && !line_loopback_en_o)
    else $error("reset state");
  chk_loop_data:
    assert property (ok && line_loopback_en_o && $past(line_loopback_en_o)
      |-> fifo_in_data_o == $past(rx_data_i, 3)) else $error("loop data");
  chk_loop_clock:
    assert property (ok && line_loopback_en_o && $past(line_loopback_en_o)
      |-> fifo_in_clock_o == $past(rx_recovered_clock_i, 3)) else $error("loop clock");
  chk_atten_line:
    assert property (ok && !atten_bypass_o && !$past(atten_bypass_o)
      |-> tx_line_clock_out_o == $past(atten_clock_i, 3)) else $error("line clock");
  chk_backplane_ref:
    assert property (backplane_ref_clock_o |-> pll_ref_clock_o) else $error("backplane ref");
  cov_loop: cover property (line_loopback_en_o && fifo_in_clock_o);
  cov_bref: cover property (backplane_ref_clock_o);
  cov_bypass: cover property (atten_bypass_o && tx_line_clock_out_o);
endmodule // ttcs_chk
bind ttcs_top ttcs_chk i_ttcs_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_data_i,
  .rx_recovered_clock_i, .atten_clock_i, .fifo_in_data_o, .fifo_in_clock_o,
  .tx_line_clock_out_o, .atten_bypass_o, .line_loopback_en_o, .tx_elastic_bypass_o,
  .pll_ref_clock_o, .backplane_ref_clock_o);

// ### tb/tb_ttcs_top.sv
/* Bench for ttcs_top: register access and clock routing per mode.
   Assumes ttcs_far_model drives the line-side pins. */
`timescale 1ns/10ps
`include "ttcs_regs.vh"
module tb_ttcs_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0;
  reg we = 1'b0;
  reg run = 1'b0;
  reg [3:0] adr = 4'h0;
  reg [3:0] sel = 4'h0;
  reg [7:0] pat = 8'h00;
  reg [31:0] dat = 32'h0000_0000;
  reg [31:0] q;
  wire [31:0] dat_o;
  wire [7:0] pins;
  wire ack, lclk, fclk, fdat, pref, bref, abyp, lbk, ebyp;
  integer n_fail = 0;
  integer cmp_count = 0;
  integer s, r, p, n;
  ttcs_far_model i_ttcs_far_model (.clk_i(clk_i), .run_i(run), .pat_i(pat), .pins_o(pins));
  ttcs_top i_ttcs_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .backplane_tx_clock_i(pins[0]), .tx_ref_clock_in_i(pins[1]),
    .rx_recovered_clock_i(pins[2]), .atten_clock_i(pins[3]), .store_clock_i(pins[4]),
    .tx_data_i(pins[5]), .rx_data_i(pins[6]), .store_data_i(pins[7]),
    .tx_line_clock_out_o(lclk), .fifo_in_clock_o(fclk), .fifo_in_data_o(fdat),
    .pll_ref_clock_o(pref), .backplane_ref_clock_o(bref), .atten_bypass_o(abyp),
    .line_loopback_en_o(lbk), .tx_elastic_bypass_o(ebyp));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  // One classic cycle; stb shares cyc since both rise and fall together
  task bus(input w, input [3:0] a, input [3:0] be, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      sel <= be;
      dat <= d;
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk_i);
      end
      if (ack !== 1'b1) n_fail = n_fail + 1;
      q = dat_o;
      cyc <= 1'b0;
    end
  endtask
  // Walks a single high pin so each output names its source; -1 means never
  task sweep(input integer el, epr, ec, ed, eb);
    begin
      for (p = 0; p < 8; p = p + 1) begin
        pat <= 8'h01 << p;
        repeat (6) @(posedge clk_i);
        chk({lclk, pref, fclk, fdat, bref}, {p == el, p == epr, p == ec, p == ed, p == eb});
      end
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial forever #10 clk_i = ~clk_i;
  initial begin
    #200000;
    n_fail = n_fail + 1;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({ebyp, abyp, lbk, bref}, 4'h8);
    bus(0, `TTCS_OFS_TIMING, 4'hf, 0);
    chk(q, 32'h0000_0001);
    bus(0, `TTCS_OFS_CTRL, 4'hf, 0);
    chk(q, 32'h0000_0002);
    bus(1, `TTCS_OFS_STATUS, 4'hf, 32'hffff_ffff);
    bus(1, 4'hc, 4'hf, 32'hffff_ffff);
    bus(0, 4'hc, 4'hf, 0);
    chk(q, 32'h0000_0000);
    bus(1, `TTCS_OFS_TIMING, 4'he, 32'h0000_0030);
    bus(0, `TTCS_OFS_STATUS, 4'hf, 0);
    chk(q, 32'h0000_0001);
    for (s = 0; s < 4; s = s + 1) begin
      for (r = 0; r < 4; r = r + 1) begin
        bus(1, `TTCS_OFS_TIMING, 4'h1, s * 16 + r * 4 + 1);
        bus(0, `TTCS_OFS_STATUS, 4'hf, 0);
        chk(q[4:0], {s > 1 && r > 0, 1'b0, s > 1 && r > 0, s == 1 && r != 3, s == 0});
        sweep(s == 0 ? 3 : s == 1 ? 1 : 0, r == 2 ? 2 : r == 3 ? 1 : 0, 0, 5, -1);
        chk(abyp, s != 0);
      end
    end
    bus(1, `TTCS_OFS_CTRL, 4'h1, 3);
    bus(1, `TTCS_OFS_TIMING, 4'h1, 1);
    sweep(3, 2, 2, 6, -1);
    chk(lbk, 1);
    run <= 1'b1;
    repeat (300) @(posedge clk_i);
    run <= 1'b0;
    bus(1, `TTCS_OFS_CTRL, 4'h1, 2);
    bus(1, `TTCS_OFS_TIMING, 4'h1, 8);
    sweep(3, 2, 4, 7, -1);
    chk(ebyp, 0);
    bus(1, `TTCS_OFS_CTRL, 4'h1, 0);
    bus(1, `TTCS_OFS_TIMING, 4'h1, 13);
    sweep(3, 1, 0, 5, 1);
    bus(1, `TTCS_OFS_TIMING, 4'h1, 1);
    bus(0, `TTCS_OFS_STATUS, 4'hf, 0);
    chk(q, 32'h0000_0009);
    bus(1, `TTCS_OFS_CTRL, 4'h1, 6);
    bus(1, `TTCS_OFS_TIMING, 4'h1, 32'h0000_0025);
    pat <= 8'h01;
    repeat (6) @(posedge clk_i);
    bus(0, `TTCS_OFS_STATUS, 4'hf, 0);
    chk(q, 32'h0000_0064);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, `TTCS_OFS_TIMING, 4'hf, 0);
    chk(q, 32'h0000_0001);
    print_verdict;
  end
endmodule // tb_ttcs_top
